// ==== cdac_pkg.sv ====
package cdac_pkg;

    // Special function register addresses
    localparam logic [7:0] CDAC_CTRL0_ADDR = 8'hB9;
    localparam logic [7:0] CDAC_CTRL1_ADDR = 8'hB5;
    localparam logic [7:0] CDAC_HIGH0_ADDR = 8'h97;
    localparam logic [7:0] CDAC_LOW0_ADDR = 8'h96;
    localparam logic [7:0] CDAC_HIGH1_ADDR = 8'hF5;
    localparam logic [7:0] CDAC_LOW1_ADDR = 8'hF4;

    // Control register fields
    localparam int CDAC_EN_BIT = 7;
    localparam int CDAC_SRC_MSB = 6;
    localparam int CDAC_SRC_LSB = 4;
    localparam int CDAC_RSVD_BIT = 3;
    localparam int CDAC_RJST_BIT = 2;
    localparam int CDAC_FS_MSB = 1;
    localparam int CDAC_FS_LSB = 0;
    localparam logic [7:0] CDAC_CTRL_RESET = 8'h73;
    localparam logic [7:0] CDAC_CTRL_WMASK = 8'hF7;
    localparam logic [7:0] CDAC_DATA_RESET = 8'h00;

    // Update source encodings
    localparam logic [2:0] CDAC_SRC_T0 = 3'h0;
    localparam logic [2:0] CDAC_SRC_T1 = 3'h1;
    localparam logic [2:0] CDAC_SRC_T2 = 3'h2;
    localparam logic [2:0] CDAC_SRC_T3 = 3'h3;
    localparam logic [2:0] CDAC_SRC_RISE = 3'h4;
    localparam logic [2:0] CDAC_SRC_FALL = 3'h5;
    localparam logic [2:0] CDAC_SRC_ANY = 3'h6;
    localparam logic [2:0] CDAC_SRC_WRITE = 3'h7;

    typedef struct packed {
        logic enable;
        logic [2:0] updateSource;
        logic reserved;
        logic rightJustify;
        logic [1:0] fullscaleSelect;
    } cdac_ctrl_t;

    typedef struct packed {
        logic t0Ovf;
        logic t1Ovf;
        logic t2LowOvf;
        logic t2HighOvf;
        logic t2Is16Bit;
        logic t3LowOvf;
        logic t3HighOvf;
        logic t3Is16Bit;
    } cdac_timer_t;

    typedef struct packed {
        logic enable;
        logic [11:0] code;
        logic [1:0] fullscaleSelect;
    } cdac_out_t;

endpackage

// ==== cdac_update_control.sv ====
// How it works
// R01: Bit 7 of each control register enables the channel when 1 and disables it when 0.
// R02: Update sources 000 to 011 copy pending data on an overflow of timer 0 to 3.
// R03: Update sources 100, 101 and 110 copy pending data on a rising, falling or any strobe edge.
// R04: Update source 111 updates the output on a write to the channel's data high byte.
// R05: The update source is the three-bit field in bits 6 to 4 of the control register.
// R06: Bit 3 of the control register always reads zero and software writes zero to it.
// R07: Bit 2 selects left justification when 0 and right justification when 1.
// R08: Bits 1 to 0 select 0.25, 0.5, 1.0 or 2.0 mA full scale for 00, 01, 10 and 11.
// R09: The second channel has its own control register with the same layout and encodings.
// R10: In timer or strobe modes data byte writes are held until the event, then high:low is latched.
// R11: In on-demand mode a low byte write has no effect until the high byte write latches both.
// R12: Timers 2 and 3 use low-byte overflow in 8-bit mode and high-byte overflow in 16-bit mode.
// R13: Left justified takes high 7:0 and low 7:4; right justified takes high 3:0 and low 7:0.
// R14: The strobe pin is synchronised before edge detection, giving one update pulse per edge.
`timescale 1ns/1ps

module cdac_update_control
    import cdac_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Special function register port
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrRead,
    output logic [7:0] sfrRdata,
    output logic sfrHit,
    // Update events
    input wire cdac_timer_t timerEvents,
    input wire logic conversion_strobe_in,
    // Converter input latches
    output cdac_out_t chan0Out,
    output cdac_out_t chan1Out,
    output logic [1:0] updatePulse
);

    cdac_ctrl_t ctrlReg [2];
    logic [7:0] highReg [2];
    logic [7:0] lowReg [2];
    logic [11:0] latchReg [2];
    logic strobeMeta;
    logic strobeSync;
    logic strobeLast;
    logic strobeRise;
    logic strobeFall;
    logic timer2Ovf;
    logic timer3Ovf;
    logic [1:0] highWrite;
    logic [1:0] trigger;

    function automatic logic [11:0] pack_word(input logic rj, input logic [7:0] hi, input logic [7:0] lo);
        if (rj) begin
            return {hi[3:0], lo}; // R13
        end
        return {hi, lo[7:4]}; // R13
    endfunction

    function automatic logic [7:0] ctrl_addr(input int ch);
        return (ch == 0) ? CDAC_CTRL0_ADDR : CDAC_CTRL1_ADDR;
    endfunction

    function automatic logic [7:0] high_addr(input int ch);
        return (ch == 0) ? CDAC_HIGH0_ADDR : CDAC_HIGH1_ADDR;
    endfunction

    function automatic logic [7:0] low_addr(input int ch);
        return (ch == 0) ? CDAC_LOW0_ADDR : CDAC_LOW1_ADDR;
    endfunction

    // Two stages before the edge detector keep metastability out of the triggers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            strobeMeta <= 1'b0;
            strobeSync <= 1'b0;
            strobeLast <= 1'b0;
        end else begin
            strobeMeta <= conversion_strobe_in; // R14
            strobeSync <= strobeMeta; // R14
            strobeLast <= strobeSync; // R14
        end
    end

    assign strobeRise = strobeSync & ~strobeLast; // R14
    assign strobeFall = ~strobeSync & strobeLast; // R14

    assign timer2Ovf = timerEvents.t2Is16Bit ? timerEvents.t2HighOvf : timerEvents.t2LowOvf; // R12
    assign timer3Ovf = timerEvents.t3Is16Bit ? timerEvents.t3HighOvf : timerEvents.t3LowOvf; // R12

    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            highWrite[ch] = sfrWrite && (sfrAddr == high_addr(ch));
            case (ctrlReg[ch].updateSource) // R05
                CDAC_SRC_T0: trigger[ch] = timerEvents.t0Ovf; // R02
                CDAC_SRC_T1: trigger[ch] = timerEvents.t1Ovf; // R02
                CDAC_SRC_T2: trigger[ch] = timer2Ovf; // R02
                CDAC_SRC_T3: trigger[ch] = timer3Ovf; // R02
                CDAC_SRC_RISE: trigger[ch] = strobeRise; // R03
                CDAC_SRC_FALL: trigger[ch] = strobeFall; // R03
                CDAC_SRC_ANY: trigger[ch] = strobeRise | strobeFall; // R03
                default: trigger[ch] = highWrite[ch]; // R04 R11
            endcase
        end
    end

    // Control registers; the reserved bit is never stored
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrlReg[0] <= CDAC_CTRL_RESET;
            ctrlReg[1] <= CDAC_CTRL_RESET;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                if (sfrWrite && (sfrAddr == ctrl_addr(ch))) begin
                    ctrlReg[ch] <= sfrWdata & CDAC_CTRL_WMASK; // R06 R09
                end
            end
        end
    end

    // Data holding bytes only; the output latch moves only on the trigger
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            highReg[0] <= CDAC_DATA_RESET;
            highReg[1] <= CDAC_DATA_RESET;
            lowReg[0] <= CDAC_DATA_RESET;
            lowReg[1] <= CDAC_DATA_RESET;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                if (highWrite[ch]) begin
                    highReg[ch] <= sfrWdata; // R10
                end
                if (sfrWrite && (sfrAddr == low_addr(ch))) begin
                    lowReg[ch] <= sfrWdata; // R10 R11
                end
            end
        end
    end

    // On-demand mode latches the byte being written together with the held low byte
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            latchReg[0] <= 12'h000;
            latchReg[1] <= 12'h000;
            updatePulse <= 2'h0;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                updatePulse[ch] <= trigger[ch];
                if (trigger[ch]) begin
                    latchReg[ch] <= pack_word(ctrlReg[ch].rightJustify, // R07 R10
                        highWrite[ch] ? sfrWdata : highReg[ch], lowReg[ch]);
                end
            end
        end
    end

    // Register outputs to the analog section
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            chan0Out <= '0;
            chan1Out <= '0;
        end else begin
            chan0Out <= {ctrlReg[0].enable, latchReg[0], ctrlReg[0].fullscaleSelect}; // R01 R08
            chan1Out <= {ctrlReg[1].enable, latchReg[1], ctrlReg[1].fullscaleSelect}; // R01 R08 R09
        end
    end

    // Read mux; unmapped addresses answer zero and drop sfrHit
    always_comb begin
        sfrRdata = 8'h00;
        sfrHit = 1'b1;
        if (sfrAddr == CDAC_CTRL0_ADDR) begin
            sfrRdata = ctrlReg[0] & CDAC_CTRL_WMASK; // R06
        end else if (sfrAddr == CDAC_CTRL1_ADDR) begin
            sfrRdata = ctrlReg[1] & CDAC_CTRL_WMASK; // R06 R09
        end else if (sfrAddr == CDAC_HIGH0_ADDR) begin
            sfrRdata = highReg[0];
        end else if (sfrAddr == CDAC_LOW0_ADDR) begin
            sfrRdata = lowReg[0];
        end else if (sfrAddr == CDAC_HIGH1_ADDR) begin
            sfrRdata = highReg[1];
        end else if (sfrAddr == CDAC_LOW1_ADDR) begin
            sfrRdata = lowReg[1];
        end else begin
            sfrHit = 1'b0;
        end
        if (!sfrRead) begin
            sfrRdata = 8'h00;
        end
    end

endmodule // cdac_update_control

// ==== cdac_props.sv ====
`timescale 1ns/1ps
module cdac_props import cdac_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrRead,
    input wire logic [7:0] sfrRdata,
    input wire logic sfrHit,
    // Events and latches
    input wire cdac_timer_t timerEvents,
    input wire logic conversion_strobe_in,
    input wire cdac_out_t chan0Out,
    input wire cdac_out_t chan1Out,
    input wire logic [1:0] updatePulse
);
    logic [7:0] ctrl_reg;
    logic [2:0] src;
    assign src = ctrl_reg[6:4];
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) ctrl_reg <= CDAC_CTRL_RESET;
        else if (sfrWrite && sfrAddr == CDAC_CTRL0_ADDR) ctrl_reg <= sfrWdata & CDAC_CTRL_WMASK;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    chk_ctrl_read: assert property (sfrRead && sfrAddr == CDAC_CTRL0_ADDR |-> sfrRdata == ctrl_reg)
        else $error("control readback wrong");
    chk_rsvd_zero: assert property (sfrRead && sfrAddr == CDAC_CTRL1_ADDR |-> !sfrRdata[3])
        else $error("reserved bit set");
    chk_unmapped_zero: assert property (sfrRead && !sfrHit |-> sfrRdata == 8'h00)
        else $error("unmapped read not zero");
    chk_timer_update: assert property (src == CDAC_SRC_T0 && timerEvents.t0Ovf |-> ##[1:2] updatePulse[0])
        else $error("timer update missing");
    chk_timer_only: assert property (src == CDAC_SRC_T0 && $stable(src) && !timerEvents.t0Ovf
        && !$past(timerEvents.t0Ovf) |=> !updatePulse[0])
        else $error("update without event");
    chk_demand_update: assert property (src == CDAC_SRC_WRITE && sfrWrite && sfrAddr == CDAC_HIGH0_ADDR
        |-> ##[1:2] updatePulse[0])
        else $error("demand update missing");
    chk_code_hold: assert property ($changed(chan0Out.code) |-> updatePulse[0] || $past(updatePulse[0]))
        else $error("code moved without update");
    chk_strobe_rise: assert property (src == CDAC_SRC_RISE && $rose(conversion_strobe_in)
        |-> ##[3:5] updatePulse[0])
        else $error("strobe update missing");
    cover property (src == CDAC_SRC_T0 && timerEvents.t0Ovf);
    cover property (src == CDAC_SRC_RISE && updatePulse[0]);
    cover property (updatePulse[1]);
endmodule // cdac_props

// ==== cdac_far_end.sv ====
`timescale 1ns/1ps
module cdac_far_end import cdac_pkg::*; (
    // Timers and strobe pin
    input wire logic clock,
    output cdac_timer_t timerEvents,
    output logic conversion_strobe_in
);
    initial begin
        timerEvents = '0;
        conversion_strobe_in = 1'b0;
    end
    // Overflows last one cycle, as a timer gives them
    task automatic pulse(input int bitPos);
        @(posedge clock);
        #1 timerEvents[bitPos] = 1'b1;
        @(posedge clock);
        #1 timerEvents[bitPos] = 1'b0;
    endtask
    // Width mode is a level the timer holds
    task automatic level(input int bitPos, input logic v);
        timerEvents[bitPos] = v;
    endtask
    task automatic strobe(input logic v);
        @(posedge clock);
        #1 conversion_strobe_in = v;
    endtask
endmodule // cdac_far_end

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench import cdac_pkg::*;;
    logic clock = 0;
    logic rst_b = 0;
    logic sfrWrite = 0;
    logic sfrRead = 1;
    logic sfrHit, conversion_strobe_in;
    logic [7:0] sfrAddr = 0;
    logic [7:0] sfrWdata = 0;
    logic [7:0] sfrRdata;
    logic [1:0] updatePulse;
    logic [11:0] exp[2] = '{12'h000, 12'h000};
    cdac_timer_t timerEvents;
    cdac_out_t out[2];
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int evBit[4] = '{7, 6, 5, 1};
    initial begin
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            stop_test();
        end
    end
    cdac_update_control dut (.clock, .rst_b, .sfrAddr, .sfrWrite, .sfrWdata, .sfrRead, .sfrRdata, .sfrHit,
        .timerEvents, .conversion_strobe_in, .chan0Out(out[0]), .chan1Out(out[1]), .updatePulse);
    cdac_far_end far (.clock, .timerEvents, .conversion_strobe_in);
    task automatic chk(input logic [15:0] g, e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, d);
        settle(1);
        sfrAddr = a;
        sfrWdata = d;
        sfrWrite = 1;
        settle(1);
        sfrWrite = 0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        settle(1);
        sfrAddr = a;
        #2 chk(sfrRdata, e);
    endtask
    task automatic data(input int ch, input logic [7:0] lo, hi);
        wr(ch ? CDAC_LOW1_ADDR : CDAC_LOW0_ADDR, lo);
        wr(ch ? CDAC_HIGH1_ADDR : CDAC_HIGH0_ADDR, hi);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        settle(10);
        rst_b = 1;
        rd(CDAC_CTRL0_ADDR, 8'h73);
        rd(CDAC_CTRL1_ADDR, 8'h73);
        chk(sfrHit, 1'b1);
        rd(8'h00, 8'h00);
        chk(sfrHit, 1'b0);
        wr(CDAC_CTRL1_ADDR, 8'hF7);
        rd(CDAC_CTRL1_ADDR, 8'hF7);
        sfrRead = 0;
        #1 chk(sfrRdata, 8'h00);
        sfrRead = 1;
        $display("registers done");
        for (int fs = 0; fs < 4; fs++) begin
            wr(CDAC_CTRL0_ADDR, {fs[1], 3'h7, 1'b0, fs[0], fs[1:0]});
            wr(CDAC_LOW0_ADDR, 8'hA5 + 8'(fs));
            settle(2);
            chk(out[0].code, exp[0]);
            wr(CDAC_HIGH0_ADDR, 8'h3C);
            settle(1);
            exp[0] = fs[0] ? {4'hC, 8'hA5 + 8'(fs)} : {8'h3C, 4'hA};
            chk(out[0], {fs[1], exp[0], fs[1:0]});
        end
        $display("on demand done");
        far.level(0, 1'b1);
        for (int ch = 0; ch < 2; ch++) begin
            for (int s = 0; s < 4; s++) begin
                wr(ch ? CDAC_CTRL1_ADDR : CDAC_CTRL0_ADDR, {1'b0, 3'(s), 4'h0});
                data(ch, 8'(8'hE0 - 16 * s), 8'(8'h41 + s + ch));
                far.pulse(s == 3 ? 2 : evBit[(s + 1) % 4]);
                settle(2);
                chk(out[ch].code, exp[ch]);
                far.pulse(evBit[s]);
                settle(2);
                exp[ch] = {8'(8'h41 + s + ch), 4'(14 - s)};
                chk(out[ch], {1'b0, exp[ch], 2'h0});
            end
        end
        $display("timers done");
        for (int s = 4; s < 7; s++) begin
            wr(CDAC_CTRL0_ADDR, {1'b0, 3'(s), 4'h0});
            for (int e = 0; e < 2; e++) begin
                data(0, 8'h80, 8'(16 * s + e));
                far.strobe(e == 0);
                settle(6);
                if (s == 6 || s - 4 == e) exp[0] = {8'(16 * s + e), 4'h8};
                chk(out[0].code, exp[0]);
            end
        end
        $display("strobe done");
        stop_test();
    end
endmodule // testbench
bind cdac_update_control cdac_props props (.clock, .rst_b, .sfrAddr, .sfrWrite, .sfrWdata, .sfrRead,
    .sfrRdata, .sfrHit, .timerEvents, .conversion_strobe_in, .chan0Out, .chan1Out, .updatePulse);
